// ---- mcr_host_model.sv ----
// Host model: issues whole-word register requests.
// Assumes the bench calls its tasks; requests change on the falling edge.
`timescale 1ns/100ps
module mcr_host_model (
  input wire logic clk,
  output mcr_pkg::mcr_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rd_valid
);
  // ****************
  // Word access
  // ****************
  initial req = '0;

  task automatic write_word(input logic [15:0] idx, input logic [15:0] w);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: w};
    @(negedge clk);
    req = '0;
  endtask : write_word

  // Answer is registered, so it is sampled one edge after the take
  task automatic read_word(input logic [15:0] idx, output logic [15:0] d, output logic v);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 16'h0000};
    @(negedge clk);
    req = '0;
    v = rd_valid;
    d = rdata;
  endtask : read_word
endmodule : mcr_host_model

// ---- mcr_misc_ctl.sv ----
// Miscellaneous control register: clock gate, interrupt pin, camera power, local resets.
// Assumes word-wide requests synchronous to clk and a synchronous active-high reset.
//
// Function
// [R01] Clock-out enable low holds clock pin low
// [R02] Interrupt enable low forces interrupt pin high
// [R03] Interrupt clear bit returns pin high
// [R04] Camera power bit cleared on suspend entry
// [R05] Encoder reset bit holds encoder in reset
// [R06] FIFO reset bit holds and empties FIFO
// [R07] Memory bus reset tri-states memory data
// [R08] Accesses are whole 16-bit words only
// [R09] Straps read in 14..8, bit 3 zero
`timescale 1ns/100ps
module mcr_misc_ctl (
  input wire logic clk,
  input wire logic srst,
  input wire mcr_pkg::mcr_req_t req,
  input wire logic clk24_src,
  input wire logic irq_event,
  input wire logic suspend_in,
  input wire logic md_drive_req,
  input wire logic [6:0] memory_data_strap,
  output logic [15:0] rdata,
  output logic rd_valid,
  output logic clock_out_pin,
  output logic int_n,
  output logic camera_power_on,
  output logic encoder_rst,
  output logic usb_fifo_rst,
  output logic memory_bus_rst,
  output logic memory_data_oe
);

  mcr_pkg::mcr_state_t st_reg;
  mcr_pkg::mcr_state_t st_next;
  logic [6:0] straps;
  logic susp;
  logic susp_entry;
  logic hit;

  // ********************************************
  // Strap capture
  // ********************************************
  mcr_strap_latch u_strap (
    .clk(clk),
    .srst(srst),
    .strap_in(memory_data_strap),
    .straps(straps)
  );

  // ********************************************
  // Next state
  // ********************************************
  // Force-suspend bit is active low
  assign susp = suspend_in | ~st_reg.ctl[mcr_pkg::MCR_BIT_FS];
  assign susp_entry = susp & ~st_reg.susp_d;
  // Port is a full word, so byte splitting cannot occur here
  assign hit = (req.index == mcr_pkg::MCR_IDX_MISC); // R08

  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.susp_d = susp;
    if (req.wr && hit)
    begin
      st_next.ctl = req.wdata & mcr_pkg::MCR_WR_MASK; // R09
    end
    // Hardware clear beats a same-cycle write
    if (susp_entry)
    begin
      st_next.ctl[mcr_pkg::MCR_BIT_PWR] = 1'b0; // R04
    end
    if (req.rd)
    begin
      st_next.rd_valid = 1'b1;
      // Unmapped index reads as zero
      st_next.rdata = hit ? mcr_pkg::mcr_compose(st_reg.ctl, straps) : 16'h0000; // R09
    end
    // Event wins over a same-cycle clear, but a clear bit still set drops it one cycle later
    st_next.irq_latch = irq_event | (st_reg.irq_latch & ~st_next.ctl[mcr_pkg::MCR_BIT_IC]); // R03
    st_next.int_n = ~(st_next.ctl[mcr_pkg::MCR_BIT_IE] & ~st_next.ctl[mcr_pkg::MCR_BIT_IC]
      & st_next.irq_latch); // R02 R03
    // Gate is a register, so the output clock is a sampled copy of the source
    st_next.clk_out = st_next.ctl[mcr_pkg::MCR_BIT_CLKEN] & clk24_src; // R01
    st_next.cam_pwr = st_next.ctl[mcr_pkg::MCR_BIT_PWR]; // R04
    st_next.enc_rst = st_next.ctl[mcr_pkg::MCR_BIT_JR]; // R05
    st_next.fifo_rst = st_next.ctl[mcr_pkg::MCR_BIT_UR]; // R06
    st_next.md_rst = st_next.ctl[mcr_pkg::MCR_BIT_MR]; // R07
    st_next.md_oe = md_drive_req & ~st_next.ctl[mcr_pkg::MCR_BIT_MR]; // R07
  end

  // ********************************************
  // State register
  // ********************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg.ctl <= mcr_pkg::MCR_RESET & mcr_pkg::MCR_WR_MASK;
      st_reg.irq_latch <= 1'b0;
      st_reg.susp_d <= 1'b0;
      st_reg.rdata <= 16'h0000;
      st_reg.rd_valid <= 1'b0;
      st_reg.clk_out <= 1'b0;
      st_reg.int_n <= 1'b1;
      st_reg.cam_pwr <= 1'b0;
      st_reg.enc_rst <= 1'b0;
      st_reg.fifo_rst <= 1'b0;
      st_reg.md_rst <= 1'b0;
      st_reg.md_oe <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign rd_valid = st_reg.rd_valid;
  assign clock_out_pin = st_reg.clk_out;
  assign int_n = st_reg.int_n;
  assign camera_power_on = st_reg.cam_pwr;
  assign encoder_rst = st_reg.enc_rst;
  assign usb_fifo_rst = st_reg.fifo_rst;
  assign memory_bus_rst = st_reg.md_rst;
  assign memory_data_oe = st_reg.md_oe;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_clk_gate_low: assert property (!st_reg.ctl[mcr_pkg::MCR_BIT_CLKEN] |-> !clock_out_pin) // R01
    else $error("clock out high while disabled");

  chk_clk_follow: assert property ( // R01
    (st_next.ctl[mcr_pkg::MCR_BIT_CLKEN] && clk24_src) |=> clock_out_pin)
    else $error("clock out not following source");

  chk_int_disabled: assert property (!st_reg.ctl[mcr_pkg::MCR_BIT_IE] |-> int_n) // R02
    else $error("interrupt low while disabled");

  chk_int_clear: assert property ($rose(st_reg.ctl[mcr_pkg::MCR_BIT_IC]) |-> int_n) // R03
    else $error("interrupt not cleared high");

  chk_int_raise: assert property ( // R02
    (irq_event && !req.wr && st_reg.ctl[mcr_pkg::MCR_BIT_IE] && !st_reg.ctl[mcr_pkg::MCR_BIT_IC])
    |=> !int_n [*1] ##1 (int_n || st_reg.irq_latch))
    else $error("pending interrupt not driven low");

  chk_pwr_suspend: assert property (susp_entry |=> !camera_power_on) // R04
    else $error("camera power kept on suspend entry");

  chk_enc_rst_write: assert property ( // R05
    (req.wr && hit) |=> encoder_rst == $past(req.wdata[mcr_pkg::MCR_BIT_JR]))
    else $error("encoder reset does not follow write");

  chk_fifo_hold: assert property ( // R06
    (usb_fifo_rst && !(req.wr && hit)) |=> usb_fifo_rst)
    else $error("fifo reset dropped without write");

  chk_md_hiz: assert property (memory_bus_rst |-> !memory_data_oe) // R07
    else $error("memory data driven during reset");

  chk_read_word: assert property ( // R09
    (req.rd && hit) |=> rd_valid && rdata == mcr_pkg::mcr_compose($past(st_reg.ctl), $past(straps)))
    else $error("read data mismatch");

  chk_rsvd_zero: assert property (rd_valid |-> !rdata[mcr_pkg::MCR_BIT_RSVD]) // R09
    else $error("reserved bit reads one");

  // Each write lands on the pins at the same edge that takes it
  chk_fifo_rst_write: assert property ( // R06
    (req.wr && hit) |=> usb_fifo_rst == $past(req.wdata[mcr_pkg::MCR_BIT_UR]))
    else $error("fifo reset does not follow write");

  chk_md_rst_write: assert property ( // R07
    (req.wr && hit) |=> memory_bus_rst == $past(req.wdata[mcr_pkg::MCR_BIT_MR]))
    else $error("memory bus reset does not follow write");

  // A same-cycle suspend entry overrides the written power bit
  chk_pwr_write: assert property ( // R04
    (req.wr && hit && !susp_entry) |=> camera_power_on == $past(req.wdata[mcr_pkg::MCR_BIT_PWR]))
    else $error("camera power does not follow write");

  chk_md_oe_drive: assert property ( // R07
    (md_drive_req && !st_next.ctl[mcr_pkg::MCR_BIT_MR]) |=> memory_data_oe)
    else $error("memory data not driven when allowed");

  chk_md_oe_idle: assert property (!md_drive_req |=> !memory_data_oe) // R07
    else $error("memory data driven without request");

  chk_clk_src_low: assert property (!clk24_src |=> !clock_out_pin) // R01
    else $error("clock out high while source low");

  chk_int_idle: assert property ((!irq_event && !st_reg.irq_latch) |=> int_n) // R02
    else $error("interrupt low with nothing pending");

  chk_int_clear_hold: assert property (st_reg.ctl[mcr_pkg::MCR_BIT_IC] |-> int_n) // R03
    else $error("interrupt low while clear bit set");

  chk_unmapped_read: assert property ((req.rd && !hit) |=> rd_valid && rdata == 16'h0000) // R09
    else $error("unmapped read not zero");

  chk_rd_idle: assert property (!req.rd |=> !rd_valid) // R09
    else $error("read answer without request");

  // Straps move only under reset, so readback stays put between resets
  chk_strap_hold: assert property (1'b1 |=> $stable(straps)) // R09
    else $error("strap capture changed outside reset");

  // ********************************************
  // Coverage
  // ********************************************
  cov_write: cover property (req.wr && hit);
  cov_int_low: cover property ($fell(int_n));
  cov_suspend: cover property (susp_entry && camera_power_on);
  cov_read: cover property (rd_valid);
  cov_force_suspend: cover property (susp_entry && !suspend_in);

endmodule : mcr_misc_ctl

// ---- mcr_misc_ctl_test.sv ----
// Self-checking bench for the miscellaneous control register.
// Assumes the host model drives all register requests.
`timescale 1ns/100ps
module mcr_misc_ctl_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk24_src = 1'b0;
  logic irq_event = 1'b0;
  logic suspend_in = 1'b0;
  logic md_drive_req = 1'b1;
  logic [6:0] strap = 7'h5A;
  mcr_pkg::mcr_req_t req;
  logic [15:0] rdata;
  logic rd_valid, clock_out_pin, int_n, camera_power_on;
  logic encoder_rst, usb_fifo_rst, memory_bus_rst, memory_data_oe;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] d;
  logic v;
  // Outputs packed: 6 clk, 5 int_n, 4 power, 3 enc, 2 fifo, 1 md rst, 0 oe
  wire [15:0] outs = {9'h000, clock_out_pin, int_n, camera_power_on, encoder_rst,
    usb_fifo_rst, memory_bus_rst, memory_data_oe};

  always #25 clk = ~clk;

  mcr_host_model host (.clk(clk), .req(req), .rdata(rdata), .rd_valid(rd_valid));

  mcr_misc_ctl dut (.clk(clk), .srst(srst), .req(req), .clk24_src(clk24_src),
    .irq_event(irq_event), .suspend_in(suspend_in), .md_drive_req(md_drive_req),
    .memory_data_strap(strap), .rdata(rdata), .rd_valid(rd_valid),
    .clock_out_pin(clock_out_pin), .int_n(int_n), .camera_power_on(camera_power_on),
    .encoder_rst(encoder_rst), .usb_fifo_rst(usb_fifo_rst),
    .memory_bus_rst(memory_bus_rst), .memory_data_oe(memory_data_oe));

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Extra cycle lets registered outputs settle
  task automatic wr(input logic [15:0] w);
    host.write_word(16'h0000, w);
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
    host.read_word(idx, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask : rd

  task automatic pulse_irq();
    irq_event = 1'b1;
    @(negedge clk);
    irq_event = 1'b0;
    @(negedge clk);
  endtask : pulse_irq

  task automatic results();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ****************
  // Sequence
  // ****************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    rd(16'h0000, 16'hDAC0);
    check(outs, 16'h0021);
    md_drive_req = 1'b0;
    repeat (2) @(negedge clk);
    check(outs, 16'h0020);
    md_drive_req = 1'b1;
    wr(16'hFFFF);
    check(outs, 16'h003E);
    rd(16'h0000, 16'hDAF7);
    clk24_src = 1'b1;
    wr(16'h8000);
    check(outs, 16'h0021);
    wr(16'h8080);
    check(outs, 16'h0061);
    clk24_src = 1'b0;
    pulse_irq();
    check(outs, 16'h0021);
    wr(16'h8040);
    check(outs, 16'h0001);
    wr(16'h8060);
    check(outs, 16'h0021);
    wr(16'h8040);
    check(outs, 16'h0021);
    pulse_irq();
    check(outs, 16'h0001);
    wr(16'h8010);
    check(outs, 16'h0031);
    suspend_in = 1'b1;
    repeat (3) @(negedge clk);
    check(outs, 16'h0021);
    suspend_in = 1'b0;
    // Force-suspend bit low counts as suspend entry
    wr(16'h0010);
    check(outs, 16'h0021);
    rd(16'h0000, 16'h5A00);
    // Second reset recaptures new strap levels
    strap = 7'h25;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd(16'h0000, 16'hA5C0);
    check(outs, 16'h0021);
    rd(16'h0001, 16'h0000);
    results();
  end
endmodule : mcr_misc_ctl_test

// ---- mcr_pkg.sv ----
// Constants, field layout and carrier types of the miscellaneous control register.
// Assumes one system clock and a synchronous active-high chip reset.
package mcr_pkg;

  // ********************************************
  // Register map
  // ********************************************
  localparam logic [15:0] MCR_IDX_MISC = 16'h0000;
  localparam logic [15:0] MCR_RESET = 16'hFFC0;
  // Writable bits: 15, 7..4, 2..0
  localparam logic [15:0] MCR_WR_MASK = 16'h80F7;

  // ********************************************
  // Field positions
  // ********************************************
  localparam int MCR_BIT_FS = 15;
  localparam int MCR_STRAP_LO = 8;
  localparam int MCR_STRAP_HI = 14;
  localparam int MCR_BIT_CLKEN = 7;
  localparam int MCR_BIT_IE = 6;
  localparam int MCR_BIT_IC = 5;
  localparam int MCR_BIT_PWR = 4;
  localparam int MCR_BIT_RSVD = 3;
  localparam int MCR_BIT_JR = 2;
  localparam int MCR_BIT_UR = 1;
  localparam int MCR_BIT_MR = 0;
  localparam int MCR_STRAP_W = 7;
  localparam logic [6:0] MCR_STRAP_RESET = 7'h7F;

  // ********************************************
  // Carriers
  // ********************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } mcr_req_t;

  typedef struct packed {
    logic [15:0] ctl;
    logic irq_latch;
    logic susp_d;
    logic [15:0] rdata;
    logic rd_valid;
    logic clk_out;
    logic int_n;
    logic cam_pwr;
    logic enc_rst;
    logic fifo_rst;
    logic md_rst;
    logic md_oe;
  } mcr_state_t;

  typedef struct packed {
    logic [6:0] straps;
  } mcr_strap_t;

  // Read-back word: straps in 14..8, reserved bit 3 forced to zero
  function automatic logic [15:0] mcr_compose(input logic [15:0] ctl, input logic [6:0] straps);
    logic [15:0] w;
    w = ctl & MCR_WR_MASK;
    w[MCR_STRAP_HI:MCR_STRAP_LO] = straps;
    w[MCR_BIT_RSVD] = 1'b0;
    return w;
  endfunction : mcr_compose

endpackage : mcr_pkg

// ---- mcr_strap_latch.sv ----
// Strap capture for the memory-data configuration pins.
// Assumes straps are stable while srst is held and synchronous to clk.
`timescale 1ns/100ps
module mcr_strap_latch (
  input wire logic clk,
  input wire logic srst,
  input wire logic [6:0] strap_in,
  output logic [6:0] straps
);

  mcr_pkg::mcr_strap_t st_reg;
  mcr_pkg::mcr_strap_t st_next;

  // ********************************************
  // Capture
  // ********************************************
  // Sampled on every reset cycle, so the last level before release is kept
  always_comb
  begin
    st_next = st_reg;
    if (srst)
    begin
      st_next.straps = strap_in;
    end
  end

  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  assign straps = st_reg.straps;

endmodule : mcr_strap_latch
